// ===== test_vdds_top.sv
// Self-checking bench for vdds_top with a processor model on the code pins.
// Assumes the 40 MHz core clock and the package constants.
`default_nettype none

module test_vdds_top
  import vdds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  vdds_mode_type mode = VDDS_MODE_JUMP_A;
  vdds_code_type next_code = 8'h00;
  vdds_code_type code;
  logic [7:0] acc;
  logic [7:0] dac;
  logic pulse;
  logic slew;
  int fails = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  vdds_cpu_model cpu (.i_core_clk(clk), .i_next_code(next_code), .o_voltage_select_code(code));
  vdds_top dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_dac_mode(mode),
    .i_voltage_select_code(code), .o_accepted_code(acc), .o_code_accept(pulse),
    .o_dac_level(dac), .o_slewing(slew));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task put(input vdds_mode_type m, input vdds_code_type c);
    @(posedge clk);
    mode <= m;
    next_code <= c;
  endtask : put
  // Pin change lands one edge after put; then 3 ticks of 13 cycles
  task wait_accept;
    int n;
    n = 0;
    #1;
    while (pulse !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(8'(n >= 27 && n <= 42), 8'h01);
  endtask : wait_accept
  task wait_slew(input int limit);
    int n;
    n = 0;
    while (slew !== 1'b0 && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_slew
  task t_jump;
    for (int i = 0; i < 2; i++) begin
      put(vdds_mode_type'(i), 8'(i + 1));
      wait_accept();
      check(acc, 8'(i + 1));
      check(dac, 8'(i));
      @(posedge clk);
      #1;
      check(dac, 8'(i + 1));
      check(8'(slew), 8'h00);
      check(8'(pulse), 8'h00);
      repeat (80) @(posedge clk);
    end
  endtask : t_jump
  // Code held under two sample periods must be ignored
  task t_glitch;
    int seen;
    seen = 0;
    put(VDDS_MODE_JUMP_B, 8'h07);
    for (int k = 0; k < 70; k++) begin
      @(posedge clk);
      if (k == 10) next_code <= 8'h02;
      #1;
      if (pulse !== 1'b0) seen++;
    end
    check(8'(seen), 8'h00);
    check(acc, 8'h02);
    check(dac, 8'h02);
  endtask : t_glitch
  task t_slew(input vdds_mode_type m, input vdds_code_type c, input int steps);
    int n;
    time t0;
    put(m, c);
    wait_accept();
    @(posedge clk);
    #1;
    check(8'(slew), 8'h01);
    t0 = $time;
    wait_slew(steps * 121 + 130);
    n = int'(($time - t0) / 25);
    check(8'(n >= (steps - 1) * 121 && n <= steps * 121 + 1), 8'h01);
    check(dac, c);
  endtask : t_slew
  task t_retarget;
    logic [7:0] peak;
    put(VDDS_MODE_SLEW_A, 8'h14);
    wait_accept();
    repeat (300) @(posedge clk);
    put(VDDS_MODE_SLEW_A, 8'h00);
    wait_accept();
    // Two or three steps downward from wherever the upward slew had got to
    peak = dac;
    repeat (250) @(posedge clk);
    #1;
    check(8'(int'(dac) + 2 <= int'(peak) && int'(dac) + 3 >= int'(peak)), 8'h01);
    wait_slew(4000);
    check(dac, 8'h00);
    check(8'(slew), 8'h00);
  endtask : t_retarget
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check(acc, 8'h00);
    check(dac, 8'h00);
    check(8'(pulse), 8'h00);
    check(8'(slew), 8'h00);
    t_jump();
    t_glitch();
    t_slew(VDDS_MODE_SLEW_A, 8'h0a, 8);
    t_slew(VDDS_MODE_SLEW_B, 8'h04, 6);
    t_retarget();
    wrap_up();
  end
  initial begin
    #2000000;
    fails++;
    wrap_up();
  end
endmodule : test_vdds_top

`default_nettype wire

// ===== vdds_cpu_model.sv
// Processor side: drives the voltage-select code, changing just after an edge.
// Assumes the bench chooses each new code and its spacing.
`default_nettype none

module vdds_cpu_model
  import vdds_pkg::*;
(
  input wire logic i_core_clk, // Core clock
  input wire vdds_code_type i_next_code, // Code the bench wants presented
  output vdds_code_type o_voltage_select_code // Code pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bench keeps jump-mode moves to one step, spaced over 2 us
  always_ff @(posedge i_core_clk) begin
    o_voltage_select_code <= i_next_code;
  end
endmodule : vdds_cpu_model

`default_nettype wire

// ===== vdds_pkg.sv
// Types shared by the voltage-select debounce and DAC slew block.
// Assumes vdds_regs.svh is on the include path.
`default_nettype none
`include "vdds_regs.svh"

package vdds_pkg;

  typedef logic [`VDDS_CODE_W-1:0] vdds_code_type;

  // DAC modes: two single-step (jump) modes and two multi-step (slew) modes
  typedef enum logic [1:0] {
    VDDS_MODE_JUMP_A = 2'h0,
    VDDS_MODE_JUMP_B = 2'h1,
    VDDS_MODE_SLEW_A = 2'h2,
    VDDS_MODE_SLEW_B = 2'h3
  } vdds_mode_type;

  typedef enum logic {
    VDDS_ST_IDLE = 1'b0,
    VDDS_ST_SLEW = 1'b1
  } vdds_state_type;

endpackage : vdds_pkg

`default_nettype wire

// ===== vdds_regs.svh
// Timing and reset constants for the voltage-select debounce and DAC slew block.
// Assumes a single 40 MHz core clock; included by its bare name.
`ifndef VDDS_REGS_SVH
`define VDDS_REGS_SVH

// Core clock rate in Hz
`define VDDS_CLK_HZ 40000000
// Sample clock for the voltage-select inputs, in Hz
`define VDDS_SAMPLE_HZ 3000000
// DAC stepping clock in slewing modes, in Hz
`define VDDS_STEP_HZ 330000
// Core cycles per sample tick, rounded down so the sample rate is never slower
`define VDDS_SAMPLE_DIV (`VDDS_CLK_HZ / `VDDS_SAMPLE_HZ)
// Core cycles per step tick
`define VDDS_STEP_DIV (`VDDS_CLK_HZ / `VDDS_STEP_HZ)
// Consecutive equal samples needed before a new code is believed
`define VDDS_STABLE_SAMPLES 2'h3
// Width of the code and of the DAC level (one LSB is one 6.25 mV step)
`define VDDS_CODE_W 8
// Reset value of the accepted code and of the DAC level
`define VDDS_CODE_RST 8'h00

`endif

// ===== vdds_tick_gen.sv
// Free-running divider giving one-cycle ticks every DIV core cycles.
// Assumes the core clock and the active-low asynchronous reset of the block.
`default_nettype none

module vdds_tick_gen #(
  parameter int unsigned DIV = 13
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_b,    // Asynchronous reset, active low
  vdds_tick_if.gen tick_out    // One-cycle tick every DIV cycles
);

  localparam int unsigned CW = $clog2(DIV);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic tick;
  logic next_tick;

  always_comb begin
    if (count == CW'(DIV - 1)) begin
      next_count = '0;
      next_tick = 1'b1;
    end else begin
      next_count = count + CW'(1);
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign tick_out.tick = tick;

endmodule : vdds_tick_gen

`default_nettype wire

// ===== vdds_tick_if.sv
// Tick carrier between a tick generator and the logic it paces.
// Assumes a single clock domain shared by both ends.
`default_nettype none

interface vdds_tick_if;
  logic tick;
  modport gen (output tick);
  modport use_tick (input tick);
endinterface : vdds_tick_if

`default_nettype wire

// ===== vdds_top.sv
// Voltage-select debounce and reference DAC update for a multiphase regulator.
// Assumes the code inputs are already synchronous to i_core_clk and that the
// code is presented as a DAC level in 6.25 mV units (table lookup is outside).
// Limitation: both dividers round down, so sampling and stepping run slightly
// fast of their nominal rates rather than slow.
//
// Behaviour
// - The DAC mode decides whether a validated code makes the DAC jump or slew.
// - The code inputs are sampled on every tick of an internal 3 MHz clock.
// - A differing code is accepted only after three equal consecutive samples.
// - In the jump modes the DAC takes a code validated outside a slew at once, with no steps.
// - In the slew modes the DAC moves one 6.25 mV step per 330 kHz tick until equal.
`default_nettype none
`include "vdds_regs.svh"

module vdds_top
  import vdds_pkg::*;
(
  input wire logic i_core_clk,                       // Core clock, 40 MHz
  input wire logic i_rst_b,                          // Asynchronous reset, active low
  input wire vdds_mode_type i_dac_mode,              // Active DAC mode
  input wire vdds_code_type i_voltage_select_code,   // Code from the processor
  output logic [`VDDS_CODE_W-1:0] o_accepted_code,   // Last validated code
  output logic o_code_accept,                        // Pulse when a code is validated
  output logic [`VDDS_CODE_W-1:0] o_dac_level,       // Reference DAC level
  output logic o_slewing                             // High while the DAC is stepping
);

  ////////////////////////////////////////////////////////////////////////////
  // Tick generators

  vdds_tick_if sample_tick_if ();
  vdds_tick_if step_tick_if ();

  // Both dividers free-run from reset, so the first step of a slew lands anywhere
  // within one step period after the acceptance; later steps are a full period apart
  vdds_tick_gen #(
    .DIV(`VDDS_SAMPLE_DIV)
  ) u_sample_tick (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .tick_out(sample_tick_if.gen)
  );

  vdds_tick_gen #(
    .DIV(`VDDS_STEP_DIV)
  ) u_step_tick (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .tick_out(step_tick_if.gen)
  );

  logic sample_tick;
  logic step_tick;

  assign sample_tick = sample_tick_if.tick;
  assign step_tick = step_tick_if.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Debounce of the code inputs

  vdds_code_type last_sample;
  vdds_code_type next_last_sample;
  logic [1:0] match_count;
  logic [1:0] next_match_count;
  vdds_code_type accepted_code;
  vdds_code_type next_accepted_code;
  logic code_accept;
  logic next_code_accept;
  logic reading_differs;
  logic reading_is_new;
  logic [1:0] run_length;
  logic run_complete;

  // Readings are compared with the last tick's reading, not with the pins of the
  // previous core cycle, so a glitch between two ticks is never seen at all
  assign reading_differs = (i_voltage_select_code != last_sample);
  // Only a code that differs from the one in force is worth accepting
  assign reading_is_new = (i_voltage_select_code != accepted_code);

  // Run of equal readings including this tick; a changed reading restarts it and
  // it saturates at three, so a code held for a long time cannot wrap and re-fire
  assign run_length = reading_differs ? 2'h1 :
                      (match_count == `VDDS_STABLE_SAMPLES) ? match_count :
                      match_count + 2'h1;
  assign run_complete = (run_length == `VDDS_STABLE_SAMPLES);

  always_comb begin
    next_last_sample = last_sample;
    next_match_count = match_count;
    next_accepted_code = accepted_code;
    next_code_accept = 1'b0;
    if (sample_tick) begin
      next_last_sample = i_voltage_select_code;
      next_match_count = run_length;
      // Until the run completes the previous code stays in force
      if (run_complete && reading_is_new) begin
        next_accepted_code = i_voltage_select_code;
        next_code_accept = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_sample <= `VDDS_CODE_RST;
      match_count <= 2'h0;
      accepted_code <= `VDDS_CODE_RST;
      code_accept <= 1'b0;
    end else begin
      last_sample <= next_last_sample;
      match_count <= next_match_count;
      accepted_code <= next_accepted_code;
      code_accept <= next_code_accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DAC update: jump or slew

  vdds_state_type state;
  vdds_state_type next_state;
  vdds_code_type dac_level;
  vdds_code_type next_dac_level;
  logic slewing;
  logic next_slewing;

  logic mode_slews;
  logic target_above;
  logic target_below;
  logic slew_needed;

  // Upper bit of the mode separates the slewing pair from the jump pair
  assign mode_slews = (i_dac_mode == VDDS_MODE_SLEW_A) ||
                      (i_dac_mode == VDDS_MODE_SLEW_B);

  // Sign of target minus DAC picks the direction of each step
  assign target_above = (accepted_code > dac_level);
  assign target_below = (accepted_code < dac_level);
  // A code that lands on the present level needs no slew at all
  assign slew_needed = target_above || target_below;

  // The mode is read in the cycle of the acceptance; a later mode change does not
  // stop a slew that is already running
  always_comb begin
    next_state = state;
    next_dac_level = dac_level;
    unique case (state)
      VDDS_ST_IDLE: begin
        if (code_accept) begin
          if (!mode_slews) begin
            next_dac_level = accepted_code;
          end else if (slew_needed) begin
            next_state = VDDS_ST_SLEW;
          end
        end
      end
      VDDS_ST_SLEW: begin
        // Target is read live, so a code accepted mid-slew retargets from here
        if (step_tick) begin
          if (target_above) begin
            next_dac_level = dac_level + 8'h01;
          end else if (target_below) begin
            next_dac_level = dac_level - 8'h01;
          end
        end
        // Compared with the code being accepted now, so a retarget onto the
        // present level ends the slew on the edge of the acceptance itself
        if (next_dac_level == next_accepted_code) begin
          next_state = VDDS_ST_IDLE;
        end
      end
    endcase
    next_slewing = (next_state == VDDS_ST_SLEW);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= VDDS_ST_IDLE;
      dac_level <= `VDDS_CODE_RST;
      slewing <= 1'b0;
    end else begin
      state <= next_state;
      dac_level <= next_dac_level;
      slewing <= next_slewing;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign o_accepted_code = accepted_code;
  assign o_code_accept = code_accept;
  assign o_dac_level = dac_level;
  assign o_slewing = slewing;

endmodule : vdds_top

`default_nettype wire

// ===== vdds_top_assertions.sv
// Port checker for vdds_top.
// Assumes one clock and the active-low asynchronous reset.
`default_nettype none
`include "vdds_regs.svh"

module vdds_top_checker
  import vdds_pkg::*;
(
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst_b, // Reset, active low
  input wire vdds_mode_type i_dac_mode, // Mode
  input wire vdds_code_type i_voltage_select_code, // Code pins
  input wire logic [`VDDS_CODE_W-1:0] o_accepted_code, // Accepted code
  input wire logic o_code_accept, // Accept pulse
  input wire logic [`VDDS_CODE_W-1:0] o_dac_level, // DAC level
  input wire logic o_slewing // Slewing
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] prev_dac;
  logic [7:0] gap;
  // Cycles since the DAC last moved, saturating
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_dac <= 8'h00;
      gap <= 8'h00;
    end else begin
      prev_dac <= o_dac_level;
      gap <= (o_dac_level != prev_dac) ? 8'h00 : ((gap == 8'hff) ? gap : gap + 8'h01);
    end
  end
  a_accept_stable: assert property (o_code_accept |-> o_accepted_code == $past(i_voltage_select_code, 1)
    && o_accepted_code == $past(i_voltage_select_code, 14)
    && o_accepted_code == $past(i_voltage_select_code, 27)) else $error("code taken unstable");
  a_accept_new: assert property (o_code_accept |-> $changed(o_accepted_code))
    else $error("accept without new code");
  a_code_holds: assert property (!o_code_accept |-> $stable(o_accepted_code))
    else $error("accepted code moved silently");
  a_jump_load: assert property (o_code_accept && i_dac_mode < 2'h2 |=>
    o_dac_level == $past(o_accepted_code) && !o_slewing) else $error("jump not loaded");
  a_slew_start: assert property (o_code_accept && i_dac_mode >= 2'h2 &&
    o_accepted_code != o_dac_level |=> o_slewing) else $error("slew not started");
  a_slew_step: assert property ($past(o_slewing) && $changed(o_dac_level) |-> o_dac_level ==
    (($past(o_accepted_code) > $past(o_dac_level)) ? $past(o_dac_level) + 8'h01
    : $past(o_dac_level) - 8'h01)) else $error("bad slew step");
  a_step_rate: assert property ($past(o_slewing) && $changed(o_dac_level) |-> gap >= 8'h77)
    else $error("slew step too early");
  a_slew_end: assert property (o_slewing |-> o_dac_level != o_accepted_code)
    else $error("slewing at target");
  c_jump: cover property (o_code_accept && i_dac_mode < 2'h2);
  c_slew: cover property (o_code_accept && i_dac_mode >= 2'h2);
  c_done: cover property ($fell(o_slewing));
endmodule : vdds_top_checker

bind vdds_top vdds_top_checker chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_dac_mode(i_dac_mode), .i_voltage_select_code(i_voltage_select_code),
  .o_accepted_code(o_accepted_code), .o_code_accept(o_code_accept),
  .o_dac_level(o_dac_level), .o_slewing(o_slewing));

`default_nettype wire
